// ### rtl/tdc_map.svh
// Register addresses, field positions, reset values and timing figures of the timer.
// Assumes inclusion by the timer module, the property module and the bench only.
`ifndef TDC_MAP_SVH
`define TDC_MAP_SVH

`define TDC_ADDR_CTRL       32'h50004000
`define TDC_ADDR_CAPCFG     32'h50004004
`define TDC_ADDR_STATUS     32'h50004008
`define TDC_ADDR_RES1       32'h5000400c
`define TDC_ADDR_RES2       32'h50004010
`define TDC_ADDR_CLEAR      32'h50004014

`define TDC_CTRL_RESET      17'h00000
`define TDC_CAPCFG_RESET    28'h0000000

`define TDC_CTRL_GATE       16
`define TDC_CTRL_SRC        15
`define TDC_CTRL_WRAPMAX    14
`define TDC_CTRL_IRQEN      13
`define TDC_CTRL_DOWN       12
`define TDC_CTRL_RUN        11

`define TDC_CAP_STRIDE      14
`define TDC_CAP_STAMP       13
`define TDC_CAP_PER_LSB     7
`define TDC_CAP_IRQEN       6
`define TDC_CAP_MODE        5
`define TDC_CAP_FALL        4
`define TDC_CAP_PIN_LSB     0

`define TDC_CNT_MAX         11'h7ff
`define TDC_PIN_FIRST       4'h1
`define TDC_PIN_LAST        4'hc
`define TDC_SYNC_CYCLES     3

`endif

// ### rtl/tdc_pkg.sv
// Types shared by the timer with dual capture.
// Assumes the map header sits in the include path.
package tdc_pkg;

  typedef enum logic [2:0] {
    TDC_R_CTRL,
    TDC_R_CAPCFG,
    TDC_R_STATUS,
    TDC_R_RES1,
    TDC_R_RES2,
    TDC_R_CLEAR,
    TDC_R_NONE
  } tdc_reg_t;

  typedef struct packed {
    logic [16:0]       ctrl;
    logic [27:0]       capcfg;
    logic [11:0]       pins_m;
    logic [11:0]       pins_s;
    logic              lp_m;
    logic              lp_s;
    logic              lp_d;
    logic [1:0]        in_prev;
    logic [10:0]       cnt;
    logic              tick_pend;
    logic [1:0]        pend;
    logic [1:0]        lost;
    logic [1:0][21:0]  res;
    logic [1:0][5:0]   per_cnt;
    logic [1:0][10:0]  win_cnt;
    logic [1:0]        win_act;
    logic              wr_act;
    tdc_reg_t          wr_idx;
    logic [31:0]       rdata;
  } tdc_state_t;

endpackage

// ### rtl/tdc_timer.sv
// Timer with two capture inputs, an AHB-Lite register slave and its pin logic.
// Assumes one clock, a synchronous high reset, asynchronous port pins and low-power
// clock, and an RTC stamp driven from logic on the same clock.
//
// What this block does
// - Counter advances only while the clock gate bit is one.
// - Source bit picks low-power clock (0) or system clock (1).
// - Counting up wraps to zero at maximum or at reload value.
// - Direction bit: zero counts up, one counts down.
// - Timer interrupt passes only while its unmask bit is set.
// - Reload field sets period; low-power path adds three sync cycles.
// - Per input, stamp bit picks counter value or RTC stamp.
// - Count mode window spans window field plus one input periods.
// - Per input, unmask bit passes capture or window-done interrupt.
// - Mode bit picks capture or count; count reports ticks minus one.
// - Edge bit picks rising (0) or falling (1) events.
// - Pin select 1 to 12 routes pins 0 to 11; others unused.
// - Event while pending sets lost flag and keeps first result.
// - Status shows pending flags for both inputs and the timer.
// - Status low bits show the live counter value.
// - Capture low field holds counter or RTC low part.
// - Capture high field holds RTC high part; unused in count mode.
// - Writing ones to clear register clears flags; it reads zero.
`timescale 1ns/100ps
`include "tdc_map.svh"

module tdc_timer
  import tdc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        lp_clk,
  input  wire logic [21:0] rtc_stamp,
  input  wire logic [11:0] port_zero_pins,
  output logic             tick_irq,
  output logic [1:0]       input_irq
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Returns {routed, level} for one input's pin select.
  function automatic logic [1:0] pin_pick(input logic [11:0] pins, input logic [3:0] sel);
    logic [3:0] idx;
    idx = sel - `TDC_PIN_FIRST;
    if (sel >= `TDC_PIN_FIRST && sel <= `TDC_PIN_LAST) begin
      pin_pick = {1'b1, pins[idx]};
    end else begin
      pin_pick = 2'b00;
    end
  endfunction

  function automatic tdc_reg_t reg_decode(input logic [31:0] addr);
    case (addr)
      `TDC_ADDR_CTRL:   reg_decode = TDC_R_CTRL;
      `TDC_ADDR_CAPCFG: reg_decode = TDC_R_CAPCFG;
      `TDC_ADDR_STATUS: reg_decode = TDC_R_STATUS;
      `TDC_ADDR_RES1:   reg_decode = TDC_R_RES1;
      `TDC_ADDR_RES2:   reg_decode = TDC_R_RES2;
      `TDC_ADDR_CLEAR:  reg_decode = TDC_R_CLEAR;
      default:          reg_decode = TDC_R_NONE;
    endcase
  endfunction

  tdc_state_t s_q;
  tdc_state_t s_d;

  logic       run;
  logic       tick;
  logic       wrap;
  logic [10:0] limit;
  logic [2:0]  clr;
  logic        addr_ok;
  tdc_reg_t    a_idx;

  // ****************************************************************
  // Next state
  // ****************************************************************

  always_comb begin
    logic [1:0]  pk;
    logic        ev;
    logic        fire;
    logic        mode;
    logic [5:0]  per_max;
    logic [10:0] win_now;
    logic [10:0] low;
    pk      = 2'b00;
    ev      = 1'b0;
    fire    = 1'b0;
    mode    = 1'b0;
    per_max = 6'h00;
    win_now = 11'h000;
    low     = 11'h000;
    s_d     = s_q;

    // Two flip-flops on every asynchronous input before anything reads it.
    s_d.pins_m = port_zero_pins;
    s_d.pins_s = s_q.pins_m;
    s_d.lp_m   = lp_clk;
    s_d.lp_s   = s_q.lp_m;
    s_d.lp_d   = s_q.lp_s;

    run  = s_q.ctrl[`TDC_CTRL_RUN] & s_q.ctrl[`TDC_CTRL_GATE];
    // The low-power clock costs two sync stages and one edge stage.
    tick = run & (s_q.ctrl[`TDC_CTRL_SRC] | (s_q.lp_s & ~s_q.lp_d));
    limit = s_q.ctrl[`TDC_CTRL_WRAPMAX] ? `TDC_CNT_MAX : s_q.ctrl[10:0];
    wrap  = 1'b0;

    if (tick) begin
      if (s_q.ctrl[`TDC_CTRL_DOWN]) begin
        if (s_q.cnt == 11'h000) begin
          s_d.cnt = s_q.ctrl[10:0];
          wrap    = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 11'h001;
        end
      end else if (s_q.cnt >= limit) begin
        s_d.cnt = 11'h000;
        wrap    = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 11'h001;
      end
    end

    // Register writes land at the end of the data phase.
    clr = (s_q.wr_act && s_q.wr_idx == TDC_R_CLEAR) ? hwdata[2:0] : 3'h0;
    if (s_q.wr_act && s_q.wr_idx == TDC_R_CTRL) begin
      s_d.ctrl = hwdata[16:0];
    end
    if (s_q.wr_act && s_q.wr_idx == TDC_R_CAPCFG) begin
      s_d.capcfg = hwdata[27:0];
    end

    // A wrap in the clearing cycle keeps the flag set.
    if (clr[0]) begin
      s_d.tick_pend = 1'b0;
    end
    if (wrap) begin
      s_d.tick_pend = 1'b1;
    end

    for (int k = 0; k < 2; k++) begin
      pk      = pin_pick(s_q.pins_s, s_q.capcfg[`TDC_CAP_PIN_LSB + k*`TDC_CAP_STRIDE +: 4]);
      mode    = s_q.capcfg[`TDC_CAP_MODE + k*`TDC_CAP_STRIDE];
      per_max = s_q.capcfg[`TDC_CAP_PER_LSB + k*`TDC_CAP_STRIDE +: 6];
      s_d.in_prev[k] = pk[0];
      // A change of pin select to a pin at another level can look like an edge.
      ev = pk[1] & (s_q.in_prev[k] ^ pk[0])
         & (pk[0] ^ s_q.capcfg[`TDC_CAP_FALL + k*`TDC_CAP_STRIDE]);
      fire    = 1'b0;
      win_now = s_q.win_cnt[k] + {10'h000, tick};
      low     = s_q.capcfg[`TDC_CAP_STAMP + k*`TDC_CAP_STRIDE] ? rtc_stamp[10:0] : s_q.cnt;

      if (mode) begin
        if (s_q.win_act[k]) begin
          s_d.win_cnt[k] = win_now;
        end
        if (ev) begin
          if (!s_q.win_act[k]) begin
            s_d.win_act[k] = 1'b1;
            s_d.win_cnt[k] = 11'h000;
            s_d.per_cnt[k] = 6'h00;
          end else if (s_q.per_cnt[k] == per_max) begin
            fire           = 1'b1;
            low            = win_now - 11'h001;
            s_d.win_cnt[k] = 11'h000;
            s_d.per_cnt[k] = 6'h00;
          end else begin
            s_d.per_cnt[k] = s_q.per_cnt[k] + 6'h01;
          end
        end
      end else begin
        s_d.win_act[k] = 1'b0;
        fire           = ev;
      end

      if (clr[k+1]) begin
        s_d.pend[k] = 1'b0;
        s_d.lost[k] = 1'b0;
      end
      if (fire) begin
        if (s_d.pend[k]) begin
          s_d.lost[k] = 1'b1;
        end else begin
          s_d.pend[k] = 1'b1;
          s_d.res[k]  = {mode ? 11'h000 : rtc_stamp[21:11], low};
        end
      end
    end

    // Address phase: latch the target and prepare read data.
    addr_ok   = hsel & hready & htrans[1];
    a_idx     = reg_decode(haddr);
    s_d.wr_act = addr_ok & hwrite;
    s_d.wr_idx = a_idx;
    s_d.rdata  = 32'h00000000;
    if (addr_ok && !hwrite) begin
      case (a_idx)
        TDC_R_CTRL:   s_d.rdata = {15'h0000, s_q.ctrl};
        TDC_R_CAPCFG: s_d.rdata = {4'h0, s_q.capcfg};
        TDC_R_STATUS: s_d.rdata = {16'h0000, s_q.lost[1], s_q.lost[0], s_q.pend[1],
                                   s_q.pend[0], s_q.tick_pend, s_q.cnt};
        TDC_R_RES1:   s_d.rdata = {10'h000, s_q.res[0]};
        TDC_R_RES2:   s_d.rdata = {10'h000, s_q.res[1]};
        default:      s_d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // The slave never stretches a transfer, so hreadyout stays high.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_q.rdata;
  assign tick_irq  = s_q.tick_pend & s_q.ctrl[`TDC_CTRL_IRQEN];
  assign input_irq = {s_q.pend[1] & s_q.capcfg[`TDC_CAP_IRQEN + `TDC_CAP_STRIDE],
                      s_q.pend[0] & s_q.capcfg[`TDC_CAP_IRQEN]};

endmodule

// ### tb/tdc_pins.sv
// Model of the port pins and the low-power clock seen by the timer.
// Assumes the bench clock; the bench raises run to make the pins toggle.
`timescale 1ns/100ps
module tdc_pins (
  input  wire logic   clk,
  input  wire logic   run,
  output logic [11:0] pins,
  output logic        lp_clk
);
  logic [2:0] cnt;
  initial begin
    pins = 12'h000;
    lp_clk = 1'b0;
    cnt = 3'h0;
  end
  // Pins hold still when idle; a newly routed input still sees an edge if its pin was left high.
  always @(posedge clk) begin
    cnt <= cnt + 3'h1;
    lp_clk <= cnt[1];
    if (run && cnt == 3'h7)
      pins <= ~pins;
  end
endmodule

// ### tb/tdc_timer_properties.sv
// Port-level checks of the timer's bus slave and interrupt lines.
// Assumes binding to tdc_timer and a single clock domain.
`timescale 1ns/100ps
`include "tdc_map.svh"
module tdc_timer_properties (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        tick_irq,
  input wire logic [1:0]  input_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic rd;
  logic wr;
  assign rd = hsel && htrans[1] && !hwrite;
  assign wr = hsel && htrans[1] && hwrite;
  ready_always_a: assert property (hreadyout == 1'b1) else $error("wait state seen");
  resp_okay_a: assert property (hresp == 1'b0) else $error("error response seen");
  rdata_idle_a: assert property (!rd |=> hrdata == 32'h0) else $error("stray read data");
  clear_reads_a: assert property (
    rd && haddr == `TDC_ADDR_CLEAR |=> hrdata == 32'h0) else $error("clear reg not zero");
  unmapped_zero_a: assert property (rd && (haddr > `TDC_ADDR_CLEAR
    || haddr < `TDC_ADDR_CTRL) |=> hrdata == 32'h0) else $error("unmapped read not zero");
  status_upper_a: assert property (
    rd && haddr == `TDC_ADDR_STATUS |=> hrdata[31:16] == 16'h0) else $error("status upper");
  result_upper_a: assert property (
    rd && (haddr == `TDC_ADDR_RES1 || haddr == `TDC_ADDR_RES2) |=> hrdata[31:22] == 10'h0)
    else $error("result upper bits set");
  tick_fall_a: assert property ($fell(tick_irq) |->
    $past(wr && (haddr == `TDC_ADDR_CTRL || haddr == `TDC_ADDR_CLEAR), 2))
    else $error("tick irq dropped without write");
  irq_fall_a: assert property (($past(input_irq) & ~input_irq) != 2'h0 |->
    $past(wr && (haddr == `TDC_ADDR_CAPCFG || haddr == `TDC_ADDR_CLEAR), 2))
    else $error("input irq dropped without write");
  reset_quiet_a: assert property (@(posedge clk) disable iff (1'b0)
    sys_rst |=> tick_irq == 1'b0 && input_irq == 2'h0 && hrdata == 32'h0)
    else $error("outputs not cleared by reset");
endmodule
bind tdc_timer tdc_timer_properties i_tdc_timer_properties (.clk(clk), .sys_rst(sys_rst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .tick_irq(tick_irq), .input_irq(input_irq));

// ### tb/test_tdc_timer.sv
// Self-checking bench of the timer: registers, counting and both capture inputs.
// Assumes the map header in the include path and the pin model beside it.
`timescale 1ns/100ps
`include "tdc_map.svh"
module test_tdc_timer;
  logic clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, run = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0, input_irq;
  logic [2:0] hsize = 3'h2;
  logic [21:0] rtc = 22'h0;
  logic [11:0] pins;
  logic lp_clk, tick_irq;
  int n_fail = 0, checks = 0;
  tdc_timer i_tdc_timer (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .lp_clk(lp_clk),
    .rtc_stamp(rtc), .port_zero_pins(pins), .tick_irq(tick_irq), .input_irq(input_irq));
  tdc_pins i_tdc_pins (.clk(clk), .run(run), .pins(pins), .lp_clk(lp_clk));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Waits for input w's interrupt, or for the timer's when w is 2.
  task automatic wait_on(input int w);
    for (int n = 0; n < 400 && (w == 2 ? tick_irq : input_irq[w[0]]) !== 1'b1; n++)
      @(posedge clk);
  endtask
  task automatic close_out;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic t_regs;
    logic [31:0] r, a [7];
    a = '{32'h50004000, 32'h50004004, 32'h50004008, 32'h5000400c, 32'h50004010,
          32'h50004014, 32'h50004018};
    foreach (a[i]) begin
      bus(1'b0, a[i], 32'h0, r); chk(r, 32'h0);
    end
    // Pin selects stay zero here so no false event can be made.
    bus(1'b1, `TDC_ADDR_CAPCFG, 32'hfff83fe0, r);
    bus(1'b0, `TDC_ADDR_CAPCFG, 32'h0, r); chk(r, 32'h0ff83fe0);
    bus(1'b1, `TDC_ADDR_CAPCFG, 32'h0, r);
    $display("register test done");
  endtask
  task automatic t_timer;
    logic [31:0] r, s, c [2];
    c = '{32'h1a805, 32'h13805};
    bus(1'b1, `TDC_ADDR_CTRL, 32'h18805, r);
    repeat (40) @(posedge clk);
    chk(tick_irq, 1'b0);
    bus(1'b0, `TDC_ADDR_STATUS, 32'h0, r); chk(r[11], 1'b1);
    bus(1'b1, `TDC_ADDR_CTRL, 32'h10005, r);
    bus(1'b1, `TDC_ADDR_CLEAR, 32'h1, r);
    foreach (c[i]) begin
      bus(1'b1, `TDC_ADDR_CTRL, c[i], r);
      bus(1'b0, `TDC_ADDR_CTRL, 32'h0, r); chk(r, c[i]);
      wait_on(2); chk(tick_irq, 1'b1);
      bus(1'b0, `TDC_ADDR_STATUS, 32'h0, r); chk(r[11], 1'b1);
      chk(r[10:0] <= 11'h5, 1'b1);
      bus(1'b1, `TDC_ADDR_CTRL, c[i] & 32'hfffff7ff, r);
      bus(1'b1, `TDC_ADDR_CLEAR, 32'h1, r);
      bus(1'b0, `TDC_ADDR_STATUS, 32'h0, r); bus(1'b0, `TDC_ADDR_STATUS, 32'h0, s);
      chk(s, r); chk(r[11], 1'b0); chk(tick_irq, 1'b0);
    end
    $display("timer test done");
  endtask
  task automatic t_capture(input int k);
    logic [31:0] r;
    rtc <= 22'h1a5c3;
    bus(1'b1, `TDC_ADDR_CAPCFG, k ? 32'h08130000 : 32'h00002041, r);
    run <= 1'b1;
    wait_on(k); chk(input_irq[k], 1'b1);
    rtc <= 22'h3c3c3;
    repeat (40) @(posedge clk);
    run <= 1'b0;
    bus(1'b0, k ? `TDC_ADDR_RES2 : `TDC_ADDR_RES1, 32'h0, r); chk(r, 32'h1a5c3);
    bus(1'b0, `TDC_ADDR_STATUS, 32'h0, r); chk(r[15:12], k ? 4'ha : 4'h5);
    bus(1'b1, `TDC_ADDR_CLEAR, 32'h2 << k, r);
    bus(1'b0, `TDC_ADDR_STATUS, 32'h0, r); chk(r[15:12], 4'h0); chk(input_irq, 2'h0);
    bus(1'b1, `TDC_ADDR_CAPCFG, 32'h0, r);
    $display("capture test done");
  endtask
  task automatic t_unused;
    logic [31:0] r;
    for (int p = 13; p < 16; p++) begin
      bus(1'b1, `TDC_ADDR_CAPCFG, 32'h40 | p, r);
      run <= 1'b1;
      repeat (60) @(posedge clk);
      run <= 1'b0;
      chk(input_irq, 2'h0);
    end
    $display("unused pin test done");
  endtask
  // The counter is halted here, so a counter stamp must equal the status value.
  task automatic t_stamp;
    logic [31:0] r, s;
    bus(1'b0, `TDC_ADDR_STATUS, 32'h0, s);
    bus(1'b1, `TDC_ADDR_CAPCFG, 32'h00104000, r);
    run <= 1'b1;
    wait_on(1); chk(input_irq[1], 1'b1);
    run <= 1'b0;
    bus(1'b0, `TDC_ADDR_RES2, 32'h0, r); chk(r, {10'h000, 11'h078, s[10:0]});
    bus(1'b1, `TDC_ADDR_CLEAR, 32'h4, r);
    bus(1'b1, `TDC_ADDR_CAPCFG, 32'h0, r);
    $display("counter stamp test done");
  endtask
  // Falling edges every 16 cycles; two periods span 32 system clock ticks.
  task automatic t_count;
    logic [31:0] r;
    bus(1'b1, `TDC_ADDR_CTRL, 32'h18800, r);
    bus(1'b1, `TDC_ADDR_CAPCFG, 32'h000000f0, r);
    bus(1'b1, `TDC_ADDR_CAPCFG, 32'h000000f1, r);
    run <= 1'b1;
    wait_on(0); chk(input_irq[0], 1'b1);
    run <= 1'b0;
    bus(1'b0, `TDC_ADDR_RES1, 32'h0, r); chk(r, 32'h0000001f);
    bus(1'b1, `TDC_ADDR_CLEAR, 32'h2, r);
    bus(1'b1, `TDC_ADDR_CAPCFG, 32'h0, r);
    bus(1'b1, `TDC_ADDR_CTRL, 32'h0, r);
    $display("count mode test done");
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_timer();
    t_capture(0);
    t_capture(1);
    t_unused();
    t_stamp();
    t_count();
    close_out();
  end
endmodule
